/* File: hdl/aofc_pkg.sv */
// Constants for the output format configuration block.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package aofc_pkg;

  // Register indices as numbered by the converter; byte address is index times four
  localparam logic [7:0]  IDX_PAT_LO      = 8'h0B;
  localparam logic [7:0]  IDX_GAIN_PAT_HI = 8'h0C;
  localparam logic [7:0]  IDX_FMT         = 8'h0D;
  localparam logic [7:0]  ADDR_PAT_LO     = {IDX_PAT_LO[5:0], 2'b00};
  localparam logic [7:0]  ADDR_GAIN_PAT_HI = {IDX_GAIN_PAT_HI[5:0], 2'b00};
  localparam logic [7:0]  ADDR_FMT        = {IDX_FMT[5:0], 2'b00};
  localparam logic [7:0]  ADDR_TEST_SEL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;

  localparam int          REG_W           = 11;
  localparam logic [10:0] REG_RST         = 11'h000;
  localparam logic [10:0] GAIN_WMASK      = 11'h707;
  localparam logic [10:0] FMT_WMASK       = 11'h4F7;
  localparam logic [2:0]  TEST_SEL_RST    = 3'h0;
  localparam logic [2:0]  TEST_USER       = 3'h5;

  // Field positions
  localparam int          GAIN_LSB        = 8;
  localparam int          FMT_TWO_WIRE    = 0;
  localparam int          FMT_SDR         = 1;
  localparam int          FMT_SER16       = 2;
  localparam int          FMT_CAP_RISE    = 4;
  localparam int          FMT_COARSE      = 5;
  localparam int          FMT_LSB_FIRST   = 6;
  localparam int          FMT_BITWISE     = 7;
  localparam int          FMT_OVRD        = 10;
  localparam int          ST_UNDERRUN     = 11;
  localparam int          ST_FULL         = 12;
  localparam int          ST_EMPTY        = 13;

  // Fine gain multipliers, 4096 is unity; code 7 is undefined and kept at unity
  localparam logic [13:0] FINE_GAIN_Q12 [8] = '{14'h1000, 14'h11F4, 14'h1425, 14'h169A,
                                                14'h195C, 14'h1C74, 14'h1FED, 14'h1000};
  localparam int          GAIN_SHIFT      = 12;

  localparam int          SMP_W           = 14;
  localparam int          FIFO_DEPTH      = 32;
  localparam logic [4:0]  BITS_14         = 5'h0E;
  localparam logic [4:0]  BITS_16         = 5'h10;

  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

endpackage

/* File: hdl/aofc_top.sv */
// Output format configuration registers, sample FIFO and lane serializer.
// Assumes samples arrive on aclk, and link_clk and cfg_pins come from outside.
`timescale 1ns/1ps

module aofc_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 32
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          rdy_r;
  logic          push;
  logic          pop;

  assign push      = in_valid && rdy_r;
  assign pop       = out_ready && (cnt_r != '0);
  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  // Ready registered so the source sees a flop, not the counter compare
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != DEPTH[AW:0]);
    end
  end
endmodule // aofc_fifo

////////////////////////////////////////////////////////////////////////////////

module aofc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [13:0] smp_data,
  input  wire logic        smp_valid,
  output logic             smp_ready,
  input  wire logic        link_clk,
  input  wire logic [7:0]  cfg_pins,
  output logic             lane_a,
  output logic             lane_b,
  output logic             frame,
  output logic             coarse_gain_en
);

  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic        do_write;
  logic        wr_hit;
  logic [10:0] wr_bits;
  logic [10:0] wr_mask;

  logic [10:0] pat_lo_r, gain_hi_r, fmt_r;
  logic [2:0]  test_sel_r;
  logic        underrun_r;

  logic [7:0]  pin_s1_r, pin_s2_r;
  logic        lk_s1_r, lk_s2_r, lk_s3_r;
  logic [10:0] eff;

  logic [13:0] f_data;
  logic        f_valid;
  logic        f_ready;

  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order

  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_mask  = {{3{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wr_bits  = w_data_r[10:0];
  assign wr_hit   = (aw_addr_r == aofc_pkg::ADDR_PAT_LO) ||
                    (aw_addr_r == aofc_pkg::ADDR_GAIN_PAT_HI) ||
                    (aw_addr_r == aofc_pkg::ADDR_FMT) ||
                    (aw_addr_r == aofc_pkg::ADDR_TEST_SEL) ||
                    (aw_addr_r == aofc_pkg::ADDR_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= aofc_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_r)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
      end
      else if (!aw_hold_r && !bvalid_r)
        awready_r <= 1'b1;
      if (s_axi_wvalid && wready_r)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
      end
      else if (!w_hold_r && !bvalid_r)
        wready_r <= 1'b1;
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? aofc_pkg::RESP_OKAY : aofc_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pat_lo_r   <= aofc_pkg::REG_RST;
      gain_hi_r  <= aofc_pkg::REG_RST;
      fmt_r      <= aofc_pkg::REG_RST;
      test_sel_r <= aofc_pkg::TEST_SEL_RST;
    end
    else if (do_write)
    begin
      if (aw_addr_r == aofc_pkg::ADDR_PAT_LO)
        pat_lo_r <= (pat_lo_r & ~wr_mask) | (wr_bits & wr_mask);
      if (aw_addr_r == aofc_pkg::ADDR_GAIN_PAT_HI)
        gain_hi_r <= (gain_hi_r & ~wr_mask) | (wr_bits & wr_mask & aofc_pkg::GAIN_WMASK);
      if (aw_addr_r == aofc_pkg::ADDR_FMT)
        fmt_r <= (fmt_r & ~wr_mask) | (wr_bits & wr_mask & aofc_pkg::FMT_WMASK);
      if (aw_addr_r == aofc_pkg::ADDR_TEST_SEL && w_strb_r[0])
        test_sel_r <= w_data_r[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= aofc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= aofc_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
      unique case (s_axi_araddr)
        aofc_pkg::ADDR_PAT_LO:      rdata_r[10:0] <= pat_lo_r;
        aofc_pkg::ADDR_GAIN_PAT_HI: rdata_r[10:0] <= gain_hi_r;
        aofc_pkg::ADDR_FMT:         rdata_r[10:0] <= fmt_r;
        aofc_pkg::ADDR_TEST_SEL:    rdata_r[2:0]  <= test_sel_r;
        aofc_pkg::ADDR_STATUS:
        begin
          rdata_r[10:0]                 <= eff;
          rdata_r[aofc_pkg::ST_UNDERRUN] <= underrun_r;
          rdata_r[aofc_pkg::ST_FULL]     <= !smp_ready;
          rdata_r[aofc_pkg::ST_EMPTY]    <= !f_valid;
        end
        default:                    rresp_r <= aofc_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
    else if (!rvalid_r)
      arready_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin and link clock synchronisers

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      lk_s1_r  <= 1'b0;
      lk_s2_r  <= 1'b0;
      lk_s3_r  <= 1'b0;
    end
    else
    begin
      pin_s1_r <= cfg_pins;
      pin_s2_r <= pin_s1_r;
      lk_s1_r  <= link_clk;
      lk_s2_r  <= lk_s1_r;
      lk_s3_r  <= lk_s2_r;
    end
  end

  assign eff = fmt_r[aofc_pkg::FMT_OVRD] ? fmt_r : {3'b000, pin_s2_r & aofc_pkg::FMT_WMASK[7:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Sample FIFO

  aofc_fifo #(
    .W     (aofc_pkg::SMP_W),
    .DEPTH (aofc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (smp_data),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Word assembly, gain and lane split

  logic               two_wire, sdr, lk_rise, lk_fall, step, load, user_mode;
  logic [4:0]         nbits, steps, cnt_r;
  logic [13:0]        pattern, word14, gained;
  logic signed [28:0] prod;
  logic signed [16:0] scaled;
  logic [15:0]        w16, rev, seq, sa_nxt, sb_nxt, sh_a_r, sh_b_r;
  wire  [15:0]        bw_a, bw_b;
  logic               frame_r, coarse_r;

  assign two_wire = eff[aofc_pkg::FMT_TWO_WIRE];
  assign sdr      = two_wire && eff[aofc_pkg::FMT_SDR];
  assign lk_rise  = lk_s2_r && !lk_s3_r;
  assign lk_fall  = !lk_s2_r && lk_s3_r;
  assign step     = sdr ? (eff[aofc_pkg::FMT_CAP_RISE] ? lk_fall : lk_rise)
                        : (lk_rise || lk_fall);
  assign nbits    = eff[aofc_pkg::FMT_SER16] ? aofc_pkg::BITS_16 : aofc_pkg::BITS_14;
  assign steps    = two_wire ? {1'b0, nbits[4:1]} : nbits;
  assign load     = step && (cnt_r <= 5'h01);
  assign f_ready  = load;

  assign user_mode = (test_sel_r == aofc_pkg::TEST_USER);
  assign pattern   = {gain_hi_r[2:0], pat_lo_r};

  assign prod   = $signed(f_valid ? f_data : 14'h0000) *
                  $signed({1'b0, aofc_pkg::FINE_GAIN_Q12[gain_hi_r[10:8]]});
  assign scaled = prod[28:12];
  assign gained = (scaled > 17'sh01FFF) ? 14'h1FFF :
                  (scaled < -17'sh02000) ? 14'h2000 : scaled[13:0];
  assign word14 = user_mode ? pattern : gained;
  assign w16    = {word14, 2'b00};

  always_comb
  begin
    // Pads go last in 16x too, so LSB first starts with the real LSB
    rev = {<<{w16}};
    rev = rev << 2;
    seq = eff[aofc_pkg::FMT_LSB_FIRST] ? rev : w16;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_split
      assign bw_a[15-gi] = seq[15-2*gi];
      assign bw_b[15-gi] = seq[14-2*gi];
    end
  endgenerate
  assign bw_a[7:0] = 8'h00;
  assign bw_b[7:0] = 8'h00;

  always_comb
  begin
    sa_nxt = seq;
    sb_nxt = 16'h0000;
    if (two_wire && eff[aofc_pkg::FMT_BITWISE])
    begin
      sa_nxt = bw_a;
      sb_nxt = bw_b;
    end
    else if (two_wire)
      sb_nxt = seq << steps;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serializer; gaps in link_clk simply hold the lanes

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r   <= 5'h00;
      sh_a_r  <= 16'h0000;
      sh_b_r  <= 16'h0000;
      frame_r <= 1'b0;
    end
    else if (load)
    begin
      cnt_r   <= steps;
      sh_a_r  <= sa_nxt;
      sh_b_r  <= sb_nxt;
      frame_r <= 1'b1;
    end
    else if (step)
    begin
      cnt_r   <= cnt_r - 5'h01;
      sh_a_r  <= sh_a_r << 1;
      sh_b_r  <= sh_b_r << 1;
      frame_r <= ((cnt_r - 5'h01) > {1'b0, steps[4:1]});
    end
  end

  // Underrun is sticky, set wins over write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      underrun_r <= 1'b0;
    else if (load && !f_valid && !user_mode)
      underrun_r <= 1'b1;
    else if (do_write && aw_addr_r == aofc_pkg::ADDR_STATUS && w_strb_r[1] &&
             w_data_r[aofc_pkg::ST_UNDERRUN])
      underrun_r <= 1'b0;
  end

  // coarse gain to analog front end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      coarse_r <= 1'b0;
    else
      coarse_r <= eff[aofc_pkg::FMT_COARSE];
  end

  assign lane_a         = sh_a_r[15];
  assign lane_b         = sh_b_r[15];
  assign frame          = frame_r;
  assign coarse_gain_en = coarse_r;

endmodule // aofc_top

/* File: tb/aofc_sva.sv */
// Port checker for the output format block.
// Bound into every aofc_top; sees its ports only.
`timescale 1ns/1ps

module aofc_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        link_clk,
  input wire logic [7:0]  cfg_pins,
  input wire logic        lane_a,
  input wire logic        lane_b,
  input wire logic        frame,
  input wire logic        coarse_gain_en
);
  logic       ov_r;
  logic       c5_r;
  logic [5:0] lk_r;
  logic       eff5;
  logic       step_near;
  logic       rd_map;

  // Tracks only format writes that strobe both low bytes, which is all the bench issues
  always_ff @(posedge aclk)
    if (!aresetn)
      {ov_r, c5_r} <= 2'b00;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == aofc_pkg::ADDR_FMT && (&s_axi_wstrb[1:0]))
      {ov_r, c5_r} <= {s_axi_wdata[10], s_axi_wdata[5]};

  always_ff @(posedge aclk)
    lk_r <= {lk_r[4:0], link_clk};

  assign eff5 = ov_r ? c5_r : cfg_pins[5];
  // Synchroniser latency spread: a lane change needs a bit clock edge 2..5 cycles back
  assign step_near = |(lk_r[4:1] ^ lk_r[5:2]);
  assign rd_map = s_axi_araddr inside {aofc_pkg::ADDR_TEST_SEL, aofc_pkg::ADDR_STATUS,
    aofc_pkg::ADDR_PAT_LO, aofc_pkg::ADDR_GAIN_PAT_HI, aofc_pkg::ADDR_FMT};

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_B_AFTER_WRITE:
    assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("no write response");
  AST_B_HOLDS:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_W_BLOCKED:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_R_AFTER_ADDR:
    assert property (s_rd_take |=> s_axi_rvalid) else $error("no read data");
  AST_R_HOLDS:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_UNMAPPED:
    assert property (s_rd_take ##0 !rd_map |=>
      s_axi_rresp == aofc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_R_UPPER_ZERO:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0) else $error("rdata high bits");
  AST_COARSE_FOLLOWS:
    assert property ($stable(eff5) [*6] |-> coarse_gain_en == eff5)
    else $error("coarse gain output wrong");
  AST_LANES_ON_STEP:
    assert property ($changed({lane_a, lane_b, frame}) |-> step_near)
    else $error("lane moved without bit clock edge");
endmodule // aofc_sva

bind aofc_top aofc_sva aofc_sva_inst (.*);

/* File: tb/aofc_rx_model.sv */
// Receiver model: makes the bit clock and gathers each word off the lanes.
// Assumes lanes settle within half a bit clock of each step.
`timescale 1ns/1ps

module aofc_rx_model (
  input wire logic        run,
  input wire logic [1:0]  edge_sel,
  input wire logic        lane_a,
  input wire logic        lane_b,
  input wire logic        frame,
  output logic            link_clk,
  output logic [15:0]     word_a,
  output logic [15:0]     word_b,
  output logic [15:0]     n_words
);
  logic        lk_d;
  logic        fr_q = 1'b0;
  logic [15:0] sh_a = 16'h0;
  logic [15:0] sh_b = 16'h0;

  // Clock stands low between runs; odd phase keeps it off the aclk grid
  initial
  begin
    link_clk = 1'b0;
    word_a = 16'h0;
    word_b = 16'h0;
    n_words = 16'h0;
    #3;
    forever #40 link_clk = (run || link_clk) ? ~link_clk : 1'b0;
  end

  // Sample mid-bit, so each sample holds the previous step's bits
  assign #20 lk_d = link_clk;

  // word from frame start
  // Samples only on lk_d changes, so the step on the last edge is not seen once the clock stops
  always @(lk_d)
    if (edge_sel == 2'h0 || edge_sel == {~lk_d, lk_d})
    begin
      fr_q <= frame;
      sh_a <= (frame && !fr_q) ? {15'h0, lane_a} : {sh_a[14:0], lane_a};
      sh_b <= (frame && !fr_q) ? {15'h0, lane_b} : {sh_b[14:0], lane_b};
      if (frame && !fr_q)
      begin
        word_a <= sh_a;
        word_b <= sh_b;
        n_words <= n_words + 16'h1;
      end
    end
endmodule // aofc_rx_model

/* File: tb/tb_top.sv */
// Self-checking bench for aofc_top with a receiver model on the lanes.
// Drives AXI4-Lite, sample stream and pins from aclk.
`timescale 1ns/1ps

module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cfg_pins = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, smp_valid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, v;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [13:0] smp_data = 14'h0, p;
  logic [1:0]  s_axi_bresp, s_axi_rresp, esel = 2'h0, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        smp_ready, link_clk, lane_a, lane_b, frame, coarse_gain_en;
  logic [15:0] word_a, word_b, nw;
  logic [13:0] sq [$];
  int          seed = 16, mismatches = 0, n_checks = 0;
  localparam logic [7:0]  ADR [3] = '{8'h2C, 8'h30, 8'h34};
  localparam logic [10:0] MSK [3] = '{11'h7FF, 11'h707, 11'h4F7};
  localparam logic [10:0] FMT [8] = '{11'h400, 11'h444, 11'h482, 11'h410,
                                      11'h401, 11'h485, 11'h4D3, 11'h403};

  aofc_top aofc_top_inst (.*);
  aofc_rx_model aofc_rx_model_inst (.run(run), .edge_sel(esel), .lane_a(lane_a),
    .lane_b(lane_b), .frame(frame), .link_clk(link_clk), .word_a(word_a),
    .word_b(word_b), .n_words(nw));

  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tmo();
    mismatches++;
    $display("[FAIL] wait expected done seen timeout");
    conclude();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Response ready is raised late on purpose, so the slave must hold
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] st);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 100) tmo();
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) tmo();
  endtask

  task automatic words(input int c);
    logic [15:0] s;
    int n;
    s = nw;
    for (n = 0; n < 5000 && 16'(nw - s) < c; n++) @(posedge aclk);
    if (n == 5000) tmo();
  endtask

  // Lane contents of one word, bit sequence position 0 sent first
  function automatic logic [31:0] exp_lanes(input logic [10:0] f, input logic [13:0] x);
    logic [15:0] q, a, b;
    int h;
    q = 16'h0;
    a = 16'h0;
    b = 16'h0;
    h = (f[2] ? 16 : 14) / (f[0] ? 2 : 1);
    for (int i = 0; i < 14; i++)
      q[i] = f[6] ? x[i] : x[13 - i];
    for (int j = 0; j < h; j++)
    begin
      a[h - 1 - j] = (f[0] && f[7]) ? q[2 * j] : q[j];
      b[h - 1 - j] = !f[0] ? 1'b0 : f[7] ? q[2 * j + 1] : q[h + j];
    end
    return {b, a};
  endfunction

  ////////////////////////////////////////////////////////////
  initial
  begin
    cfg_pins <= 8'($random(seed));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ADR[k])
    begin
      rd(ADR[k]);
      chk("reset value", 32'h0, d);
      repeat (4)
      begin
        v = $random(seed);
        if (k == 1 && v[10:8] == 3'h7) v[10:8] = 3'h6;
        if (k > 0) v = v & 32'(MSK[k]);
        wr(ADR[k], v, 4'hF);
        chk("bresp", 32'(aofc_pkg::RESP_OKAY), 32'(r));
        rd(ADR[k]);
        chk("readback", 32'(v[10:0] & MSK[k]), d);
      end
    end
    wr(8'h08, 32'hFFFFFFFF, 4'hF);
    chk("unmapped bresp", 32'(aofc_pkg::RESP_SLVERR), 32'(r));
    rd(8'h08);
    chk("unmapped rresp", 32'(aofc_pkg::RESP_SLVERR), 32'(r));
    wr(ADR[2], 32'h0A0, 4'hF);
    rd(8'h04);
    chk("pin format", 32'(cfg_pins & 8'hF7), d & 32'h7FF);
    chk("coarse from pins", 32'(cfg_pins[5]), 32'(coarse_gain_en));
    v = {21'h0, 1'b1, 4'h0, ~cfg_pins[5], 5'h0};
    wr(ADR[2], v, 4'hF);
    rd(8'h04);
    chk("register format", v, d & 32'h7FF);
    chk("coarse from reg", 32'(v[5]), 32'(coarse_gain_en));
    wr(8'h00, 32'h5, 4'hF);
    run <= 1'b1;
    foreach (FMT[k])
    begin
      p = 14'($random(seed));
      wr(ADR[0], 32'(p[10:0]), 4'hF);
      wr(ADR[1], 32'(p[13:11]), 4'hF);
      wr(ADR[2], 32'(FMT[k]), 4'hF);
      esel <= (FMT[k][0] && FMT[k][1]) ? (FMT[k][4] ? 2'h1 : 2'h2) : 2'h0;
      words(3);
      chk("pattern lanes", exp_lanes(FMT[k], p), {word_b, word_a});
    end
    run <= 1'b0;
    esel <= 2'h0;
    wr(8'h00, 32'h0, 4'hF);
    wr(ADR[1], 32'h0, 4'hF);
    wr(ADR[2], 32'h400, 4'hF);
    smp_data <= 14'($random(seed));
    smp_valid <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (smp_ready)
      begin
        sq.push_back(smp_data);
        smp_data <= 14'($random(seed));
      end
    end
    smp_valid <= 1'b0;
    chk("fifo depth", 32'h20, 32'(sq.size()));
    run <= 1'b1;
    words(1);
    foreach (sq[i])
    begin
      words(1);
      chk("sample lanes", exp_lanes(11'h400, sq[i]), {word_b, word_a});
    end
    words(1);
    run <= 1'b0;
    rd(8'h04);
    chk("underrun status", 32'h2C00, d);
    wr(8'h04, 32'h800, 4'h2);
    rd(8'h04);
    chk("underrun cleared", 32'h2400, d);
    conclude();
  end
endmodule // tb_top
